// ### src/kr4_fec_pkg.sv
// Constants for the four-lane FEC status and counter register bank.
package kr4_fec_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_FORCE_LOCK = 8'hb0;
  localparam logic [7:0] IDX_LANE1_CTRL = 8'hb5;
  localparam logic [7:0] IDX_LANE1_CORR = 8'hb6;
  localparam logic [7:0] IDX_LANE1_UNCORR = 8'hb7;
  localparam logic [7:0] IDX_LANE2_CTRL = 8'hb8;
  localparam logic [7:0] IDX_LANE2_CORR = 8'hb9;
  localparam logic [7:0] IDX_LANE2_UNCORR = 8'hba;
  localparam logic [7:0] IDX_LANE3_CTRL = 8'hbb;
  localparam logic [7:0] IDX_LANE3_CORR = 8'hbc;
  localparam logic [7:0] IDX_LANE3_UNCORR = 8'hbd;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'he0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'he1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'he2;

  // ****************************************************************
  // Field positions and widths.
  // ****************************************************************
  localparam int unsigned SEQ_RESET_BIT = 0;
  localparam int unsigned FORCE_FEC_BIT = 19;
  localparam int unsigned LOCK_LSB = 20;
  localparam int unsigned LOCK_W = 4;
  localparam int unsigned FORCE_BYTE = 2;
  localparam int unsigned SEQ_BYTE = 0;
  localparam int unsigned COPY_LANES = 3;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_LOCK_LOST_BIT = 3;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;

  // ****************************************************************
  // Reset values and bus answers.
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/kr4_fec_lane_status_regs.sv
// Four-lane FEC force, lock status, lane control copies and block counters.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module kr4_fec_lane_status_regs #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Decoder status and events, lanes 1 to 3 for the counters
  input wire logic [3:0] fec_lock,
  input wire logic [2:0] corr_evt,
  input wire logic [2:0] uncorr_evt,
  // Negotiation and inherited lane-0 settings
  input wire logic an_fec_result,
  input wire logic base_r_select,
  input wire logic an_request,
  input wire logic lt_request,
  input wire logic [31:0] lane0_ctrl_in,
  // Link control outputs
  output logic fec_mode_active,
  output logic seq_restart,
  output logic an_enable,
  output logic lt_enable,
  output logic [31:0] lane0_ctrl,
  output logic [31:0] lane1_ctrl,
  output logic [31:0] lane2_ctrl,
  output logic [31:0] lane3_ctrl,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic force_fec;
    logic force_applied;
    logic seq_restart;
    logic fec_mode_active;
    logic [3:0] lock;
    logic [2:0][31:0] lane_ctrl;
    logic [2:0][31:0] corr;
    logic [2:0][31:0] uncorr;
    logic [31:0] lane0_ctrl;
    logic an_enable;
    logic lt_enable;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic irq;
  } state_s;

  state_s s;
  state_s next_s;
  logic [2:0] clr_corr;
  logic [2:0] clr_uncorr;
  logic wr_go;
  logic [8:0] rd_dec;
  logic [8:0] wr_dec;
  logic [3:0] irq_events;

  if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 11 and 32");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Returns {hit, index}; any address above the index field misses.
  function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0) && ((a >> (kr4_fec_pkg::IDX_MSB + 1)) == '0);
    return {hit, a[kr4_fec_pkg::IDX_MSB:kr4_fec_pkg::IDX_LSB]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // A read clear drops the old count first, so a same-cycle event counts as one.
  function automatic logic [31:0] count_next(input logic [31:0] cur, input logic evt,
                                             input logic clr);
    logic [31:0] base;
    base = clr ? kr4_fec_pkg::COUNT_RESET : cur;
    if (evt && !(&base)) begin
      return base + 32'h0000_0001;
    end
    return base;
  endfunction

  function automatic logic [7:0] lane_idx(input logic [7:0] first, input int unsigned l);
    return first + 8'(3 * l);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign rd_dec = decode(araddr);
  assign wr_dec = decode(s.aw_addr);
  assign wr_go = s.aw_held && s.w_held && !s.bvalid;
  // Lock loss is the fall of any lane's registered lock bit.
  always_comb begin
    irq_events = {1'b0, uncorr_evt};
    irq_events[kr4_fec_pkg::IRQ_LOCK_LOST_BIT] = |(s.lock & ~fec_lock);
  end

  always_comb begin
    next_s = s;
    clr_corr = 3'h0;
    clr_uncorr = 3'h0;
    next_s.seq_restart = 1'b0;

    // Read channel: the answer is registered one edge after the address.
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = kr4_fec_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (!rd_dec[8]) begin
        next_s.rresp = kr4_fec_pkg::RESP_SLVERR;
      end else if (rd_dec[7:0] == kr4_fec_pkg::IDX_FORCE_LOCK) begin
        next_s.rdata[kr4_fec_pkg::FORCE_FEC_BIT] = s.force_fec;
        next_s.rdata[kr4_fec_pkg::LOCK_LSB +: kr4_fec_pkg::LOCK_W] = s.lock;
      end else if (rd_dec[7:0] == kr4_fec_pkg::IDX_IRQ_STATUS) begin
        next_s.rdata[kr4_fec_pkg::IRQ_W-1:0] = s.irq_status;
      end else if (rd_dec[7:0] == kr4_fec_pkg::IDX_IRQ_CLEAR) begin
        next_s.rdata = 32'h0000_0000;
      end else if (rd_dec[7:0] == kr4_fec_pkg::IDX_IRQ_ENABLE) begin
        next_s.rdata[kr4_fec_pkg::IRQ_W-1:0] = s.irq_enable;
      end else begin
        next_s.rresp = kr4_fec_pkg::RESP_SLVERR;
        for (int l = 0; l < kr4_fec_pkg::COPY_LANES; l++) begin
          if (rd_dec[7:0] == lane_idx(kr4_fec_pkg::IDX_LANE1_CTRL, l)) begin
            next_s.rresp = kr4_fec_pkg::RESP_OKAY;
            next_s.rdata = s.lane_ctrl[l];
          end
          if (rd_dec[7:0] == lane_idx(kr4_fec_pkg::IDX_LANE1_CORR, l)) begin
            next_s.rresp = kr4_fec_pkg::RESP_OKAY;
            next_s.rdata = s.corr[l];
            clr_corr[l] = 1'b1;
          end
          if (rd_dec[7:0] == lane_idx(kr4_fec_pkg::IDX_LANE1_UNCORR, l)) begin
            next_s.rresp = kr4_fec_pkg::RESP_OKAY;
            next_s.rdata = s.uncorr[l];
            clr_uncorr[l] = 1'b1;
          end
        end
      end
    end
    next_s.arready = !next_s.rvalid;

    // Write channels are taken independently and joined before the update.
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.awready && awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (s.wready && wvalid) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (wr_go) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = kr4_fec_pkg::RESP_OKAY;
      if (!wr_dec[8]) begin
        next_s.bresp = kr4_fec_pkg::RESP_SLVERR;
      end else if (wr_dec[7:0] == kr4_fec_pkg::IDX_FORCE_LOCK) begin
        // Lock bits are read-only; only the force and sequencer bits take data.
        if (s.wstrb[kr4_fec_pkg::FORCE_BYTE]) begin
          next_s.force_fec = s.wdata[kr4_fec_pkg::FORCE_FEC_BIT];
        end
        if (s.wstrb[kr4_fec_pkg::SEQ_BYTE] && s.wdata[kr4_fec_pkg::SEQ_RESET_BIT]) begin
          next_s.seq_restart = 1'b1;
          next_s.force_applied = next_s.force_fec;
        end
      end else if (wr_dec[7:0] == kr4_fec_pkg::IDX_IRQ_STATUS) begin
        next_s.bresp = kr4_fec_pkg::RESP_OKAY;
      end else if (wr_dec[7:0] == kr4_fec_pkg::IDX_IRQ_CLEAR) begin
        if (s.wstrb[0]) begin
          next_s.irq_status = s.irq_status & ~s.wdata[kr4_fec_pkg::IRQ_W-1:0];
        end
      end else if (wr_dec[7:0] == kr4_fec_pkg::IDX_IRQ_ENABLE) begin
        if (s.wstrb[0]) begin
          next_s.irq_enable = s.wdata[kr4_fec_pkg::IRQ_W-1:0];
        end
      end else begin
        // Counters ignore writes; unknown indices answer with an error.
        next_s.bresp = kr4_fec_pkg::RESP_SLVERR;
        for (int l = 0; l < kr4_fec_pkg::COPY_LANES; l++) begin
          if (wr_dec[7:0] == lane_idx(kr4_fec_pkg::IDX_LANE1_CTRL, l)) begin
            next_s.bresp = kr4_fec_pkg::RESP_OKAY;
            next_s.lane_ctrl[l] = merge(s.lane_ctrl[l], s.wdata, s.wstrb);
          end
          if (wr_dec[7:0] == lane_idx(kr4_fec_pkg::IDX_LANE1_CORR, l) ||
              wr_dec[7:0] == lane_idx(kr4_fec_pkg::IDX_LANE1_UNCORR, l)) begin
            next_s.bresp = kr4_fec_pkg::RESP_OKAY;
          end
        end
      end
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;

    // Lane counters and status.
    for (int l = 0; l < kr4_fec_pkg::COPY_LANES; l++) begin
      next_s.corr[l] = count_next(s.corr[l], corr_evt[l], clr_corr[l]);
      next_s.uncorr[l] = count_next(s.uncorr[l], uncorr_evt[l], clr_uncorr[l]);
    end
    next_s.lock = fec_lock;
    next_s.fec_mode_active = s.force_applied || an_fec_result;
    next_s.lane0_ctrl = lane0_ctrl_in;
    next_s.an_enable = an_request && !base_r_select;
    next_s.lt_enable = lt_request && !base_r_select;

    // New events are applied after the clear, so a set in the clear cycle wins.
    next_s.irq_status = next_s.irq_status | irq_events;
    next_s.irq = |(next_s.irq_status & next_s.irq_enable);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign fec_mode_active = s.fec_mode_active;
  assign seq_restart = s.seq_restart;
  assign an_enable = s.an_enable;
  assign lt_enable = s.lt_enable;
  assign lane0_ctrl = s.lane0_ctrl;
  assign lane1_ctrl = s.lane_ctrl[0];
  assign lane2_ctrl = s.lane_ctrl[1];
  assign lane3_ctrl = s.lane_ctrl[2];
  assign irq = s.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  force_mode_a: assert property (s.force_applied |=> fec_mode_active)
    else $error("forced FEC did not select FEC mode");
  force_delay_a: assert property ($changed(s.force_applied) |-> s.seq_restart)
    else $error("force override changed without sequencer reset");
  lock_read_a: assert property ((s.arready && arvalid &&
      rd_dec == {1'b1, kr4_fec_pkg::IDX_FORCE_LOCK}) |=>
      rdata[kr4_fec_pkg::LOCK_LSB +: kr4_fec_pkg::LOCK_W] == $past(s.lock))
    else $error("lock field read back wrong");
  corr_sat_a: assert property ((&s.corr[0] && !clr_corr[0]) |=> &s.corr[0])
    else $error("corrected counter wrapped");
  uncorr_inc_a: assert property ((uncorr_evt[1] && !clr_uncorr[1] && !(&s.uncorr[1]))
      |=> s.uncorr[1] == $past(s.uncorr[1]) + 32'h0000_0001)
    else $error("uncorrected counter missed an event");
  read_clear_a: assert property (clr_corr[1] |=> rdata == $past(s.corr[1])
      && s.corr[1] == {31'h0, $past(corr_evt[1])})
    else $error("counter read did not return and clear");
  ctrl_hold_a: assert property (!wr_go |=> $stable(lane3_ctrl))
    else $error("lane control copy changed without a write");
  lane0_follow_a: assert property (##1 lane0_ctrl == $past(lane0_ctrl_in))
    else $error("lane-0 control not passed through");
  base_r_a: assert property (base_r_select |=> !an_enable && !lt_enable)
    else $error("base-R left negotiation or training enabled");
  lane3_clear_a: assert property (clr_uncorr[2] |=> s.uncorr[2] ==
      {31'h0, $past(uncorr_evt[2])})
    else $error("lane 3 counter not cleared on read");
  event_keep_a: assert property (uncorr_evt[0] |=> s.irq_status[0])
    else $error("uncorrected event lost from status");
  lock_lost_a: assert property ((|(s.lock & ~fec_lock)) |=>
      s.irq_status[kr4_fec_pkg::IRQ_LOCK_LOST_BIT])
    else $error("lost lock did not set its status bit");
  seq_pulse_a: assert property (s.seq_restart |=> !s.seq_restart)
    else $error("sequencer restart lasted more than one cycle");
  lane3_count_a: assert property ((corr_evt[2] && !clr_corr[2] && !(&s.corr[2]))
      |=> s.corr[2] == $past(s.corr[2]) + 32'h0000_0001)
    else $error("lane 3 corrected counter missed an event");

  force_seq_c: cover property (s.seq_restart && s.force_applied);
  sat_c: cover property (&s.corr[0]);
  clear_evt_c: cover property (clr_corr[0] && corr_evt[0]);
  irq_c: cover property (irq);

endmodule

`default_nettype wire

// ### test/kr4_fec_lane_status_regs_tb_top.sv
// Self-checking testbench for the four-lane FEC status and counter register bank.
`timescale 1ns/1ps
`default_nettype none

module kr4_fec_lane_status_regs_tb_top;
  logic ref_clk;
  logic rst_b;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic [3:0] fec_lock;
  logic [2:0] corr_evt, uncorr_evt;
  logic an_fec_result, base_r_select, an_request, lt_request;
  logic [31:0] lane0_ctrl_in;
  wire logic fec_mode_active, seq_restart, an_enable, lt_enable, irq;
  wire logic [31:0] lane0_ctrl, lane1_ctrl, lane2_ctrl, lane3_ctrl;
  integer seed = 33;
  int n_fail = 0;
  int total_checks = 0;
  int n_restart = 0;
  logic [31:0] exp_c [3];
  logic [31:0] exp_u [3];
  logic [31:0] d, d2, e;
  logic [3:0] s;
  logic [1:0] r;
  logic [2:0] c, u;

  kr4_fec_lane_status_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fec_lock(fec_lock), .corr_evt(corr_evt), .uncorr_evt(uncorr_evt),
    .an_fec_result(an_fec_result), .base_r_select(base_r_select), .an_request(an_request),
    .lt_request(lt_request), .lane0_ctrl_in(lane0_ctrl_in), .fec_mode_active(fec_mode_active),
    .seq_restart(seq_restart), .an_enable(an_enable), .lt_enable(lt_enable),
    .lane0_ctrl(lane0_ctrl), .lane1_ctrl(lane1_ctrl), .lane2_ctrl(lane2_ctrl),
    .lane3_ctrl(lane3_ctrl), .irq(irq));

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (seq_restart === 1'b1) n_restart++;
  end

  // ****************************************************************
  // Bus cycles, comparisons and expectations.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Address and data are raised together and each is released on its own handshake.
  task automatic wr(input logic [7:0] idx, input logic [31:0] dv, input logic [3:0] sv);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= dv;
    wstrb <= sv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, kr4_fec_pkg::RESP_OKAY});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] dv, output logic [1:0] rv);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (rvalid !== 1'b1);
    dv = rdata;
    rv = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] dv;
    logic [1:0] rv;
    rd(idx, dv, rv);
    chk(dv, exp);
    chk({30'h0, rv}, {30'h0, kr4_fec_pkg::RESP_OKAY});
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction

  function automatic logic [31:0] b0_word(input logic [3:0] lock, input logic frc);
    return {8'h00, lock, frc, 19'h0};
  endfunction

  function automatic logic [31:0] lane_out(input int l);
    return (l == 0) ? lane1_ctrl : (l == 1) ? lane2_ctrl : lane3_ctrl;
  endfunction

  function automatic logic [7:0] lidx(input logic [7:0] base, input int l);
    return 8'(base + 3 * l);
  endfunction

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end

  initial begin
    rst_b = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
    {fec_lock, corr_evt, uncorr_evt, an_fec_result, base_r_select} = '0;
    {an_request, lt_request, lane0_ctrl_in} = '0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rc(kr4_fec_pkg::IDX_FORCE_LOCK, b0_word(4'h0, 1'b0));
    for (int l = 0; l < 3; l++) begin
      rc(lidx(kr4_fec_pkg::IDX_LANE1_CORR, l), 32'h0);
      rc(lidx(kr4_fec_pkg::IDX_LANE1_UNCORR, l), 32'h0);
      d = $random(seed);
      d2 = $random(seed);
      s = 4'($random(seed));
      wr(lidx(kr4_fec_pkg::IDX_LANE1_CTRL, l), d, 4'hf);
      wr(lidx(kr4_fec_pkg::IDX_LANE1_CTRL, l), d2, s);
      rc(lidx(kr4_fec_pkg::IDX_LANE1_CTRL, l), merge(d, d2, s));
      chk(lane_out(l), merge(d, d2, s));
    end
    for (int i = 0; i < 8; i++) begin
      {base_r_select, an_request, lt_request} <= 3'(i);
      lane0_ctrl_in <= $random(seed);
      cyc(3);
      chk(lane0_ctrl, lane0_ctrl_in);
      chk({30'h0, an_enable, lt_enable}, {30'h0, an_request & ~base_r_select,
          lt_request & ~base_r_select});
    end
    an_fec_result <= 1'b1;
    cyc(2);
    chk({31'h0, fec_mode_active}, 32'h1);
    an_fec_result <= 1'b0;
    cyc(2);
    // Override alone must not switch the mode; only the sequencer restart applies it.
    wr(kr4_fec_pkg::IDX_FORCE_LOCK, 32'h0008_0000, 4'h4);
    cyc(4);
    chk({31'h0, fec_mode_active}, 32'h0);
    rd(kr4_fec_pkg::IDX_FORCE_LOCK, d, r);
    chk(d, b0_word(4'h0, 1'b1));
    wr(kr4_fec_pkg::IDX_FORCE_LOCK, d | 32'h1, 4'hf);
    cyc(4);
    chk({31'h0, fec_mode_active}, 32'h1);
    chk(32'(n_restart), 32'h1);
    for (int i = 0; i < 4; i++) begin
      fec_lock <= 4'($random(seed));
      cyc(3);
      rc(kr4_fec_pkg::IDX_FORCE_LOCK, b0_word(fec_lock, 1'b1));
    end
    for (int l = 0; l < 3; l++) begin
      exp_c[l] = 0;
      exp_u[l] = 0;
    end
    for (int i = 0; i < 200; i++) begin
      c = 3'($random(seed));
      u = 3'($random(seed));
      corr_evt <= c;
      uncorr_evt <= u;
      @(posedge ref_clk);
      for (int l = 0; l < 3; l++) begin
        exp_c[l] += 32'(c[l]);
        exp_u[l] += 32'(u[l]);
      end
    end
    corr_evt <= 3'h0;
    uncorr_evt <= 3'h0;
    cyc(2);
    wr(kr4_fec_pkg::IDX_LANE1_CORR, 32'h0, 4'hf);
    for (int l = 0; l < 3; l++) begin
      rc(lidx(kr4_fec_pkg::IDX_LANE1_CORR, l), exp_c[l]);
      rc(lidx(kr4_fec_pkg::IDX_LANE1_CORR, l), 32'h0);
      rc(lidx(kr4_fec_pkg::IDX_LANE1_UNCORR, l), exp_u[l]);
      rc(lidx(kr4_fec_pkg::IDX_LANE1_UNCORR, l), 32'h0);
    end
    // Events every cycle across a clearing read: the two reads together must see them all.
    fork
      begin
        corr_evt <= 3'b001;
        repeat (20) @(posedge ref_clk);
        corr_evt <= 3'b000;
      end
      begin
        cyc(5);
        rd(kr4_fec_pkg::IDX_LANE1_CORR, d, r);
      end
    join
    cyc(2);
    rd(kr4_fec_pkg::IDX_LANE1_CORR, d2, r);
    chk(d + d2, 32'd20);
    wr(kr4_fec_pkg::IDX_IRQ_CLEAR, 32'hf, 4'hf);
    wr(kr4_fec_pkg::IDX_IRQ_ENABLE, 32'h1, 4'hf);
    rc(kr4_fec_pkg::IDX_IRQ_STATUS, 32'h0);
    uncorr_evt <= 3'b010;
    @(posedge ref_clk);
    uncorr_evt <= 3'b000;
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    uncorr_evt <= 3'b001;
    @(posedge ref_clk);
    uncorr_evt <= 3'b000;
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rc(kr4_fec_pkg::IDX_IRQ_STATUS, 32'h3);
    wr(kr4_fec_pkg::IDX_IRQ_CLEAR, 32'h1, 4'hf);
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    rc(kr4_fec_pkg::IDX_IRQ_STATUS, 32'h2);
    fec_lock <= 4'hf;
    cyc(2);
    fec_lock <= 4'h0;
    cyc(3);
    wr(kr4_fec_pkg::IDX_IRQ_ENABLE, 32'h8, 4'hf);
    cyc(1);
    chk({31'h0, irq}, 32'h1);
    rc(kr4_fec_pkg::IDX_IRQ_STATUS, 32'ha);
    rd(8'hc0, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, kr4_fec_pkg::RESP_SLVERR});
    end_sim;
  end
endmodule

`default_nettype wire
